/* File: rtl/attp_top.sv */
// Timer-trigger conversion program table with sequencers and bus slave.
// Operation
// RL1: A rising timer five match event starts a timer-triggered sequence.
// RL2: Twelve independent byte-wide program slots, numbered 0 to 11.
// RL3: Slot byte bit 7 enables the slot; zero disables it.
// RL4: Low five bits of each slot byte select the analog input.
// RL5: Codes 0-11 valid; 12 valid only on second unit; higher codes reserved.
// RL6: Result of slot m goes to conversion result register m.
// RL7: Sequence completion raises the unit's dedicated done interrupt.
// RL8: Each of two units owns its own identical set of twelve slots.
// RL9: The two bits between enable and select always read zero.
// RL10: Slot 4k+n lives in byte n of slot register k.
// RL11: All slot registers are zero after reset, slots disabled.
// RL12: Convert enabled slots in ascending order; ignore triggers while busy.
// RL13: Software avoids reserved codes and programs slots before enabling triggers.
`timescale 1ns/100ps
module attp_top (
  input  logic                                             aclk,
  input  logic                                             aresetn,
  input  logic [7:0]                                       awaddr,
  input  logic                                             awvalid,
  output logic                                             awready,
  input  logic [31:0]                                      wdata,
  input  logic [3:0]                                       wstrb,
  input  logic                                             wvalid,
  output logic                                             wready,
  output logic [1:0]                                       bresp,
  output logic                                             bvalid,
  input  logic                                             bready,
  input  logic [7:0]                                       araddr,
  input  logic                                             arvalid,
  output logic                                             arready,
  output logic [31:0]                                      rdata,
  output logic [1:0]                                       rresp,
  output logic                                             rvalid,
  input  logic                                             rready,
  input  logic                                             timer5_match_event,
  input  attp_pkg::attp_conv_rsp_t [attp_pkg::ATTP_UNITS-1:0] conv_rsp,
  output attp_pkg::attp_conv_req_t [attp_pkg::ATTP_UNITS-1:0] conv_req,
  output logic [attp_pkg::ATTP_UNITS-1:0]                  timer_sequence_done_irq,
  output logic                                             irq
);
  import attp_pkg::*;

  typedef struct packed {
    logic [ATTP_UNITS-1:0][ATTP_SLOT_REGS-1:0][31:0] slots;
    logic [ATTP_STS_W-1:0]                           sts;
    logic [ATTP_STS_W-1:0]                           msk;
    logic [7:0]                                      awaddr;
    logic                                            aw_got;
    logic [31:0]                                     wdata;
    logic [3:0]                                      wstrb;
    logic                                            w_got;
    logic                                            awready;
    logic                                            wready;
    logic                                            bvalid;
    logic [1:0]                                      bresp;
    logic [7:0]                                      araddr;
    logic                                            rd_wait;
    logic                                            arready;
    logic                                            rvalid;
    logic [31:0]                                     rdata;
    logic [1:0]                                      rresp;
    logic                                            trig_prev;
    attp_unit_t [ATTP_UNITS-1:0]                     unit;
    attp_conv_req_t [ATTP_UNITS-1:0]                 req;
    logic [ATTP_UNITS-1:0]                           done;
    logic                                            irq;
  } attp_state_t;

  attp_state_t                             q;
  attp_state_t                             d;
  logic [ATTP_UNITS-1:0]                   mem_we;
  logic [ATTP_UNITS-1:0][ATTP_RES_W-1:0]   mem_rdata;
  logic [ATTP_UNITS-1:0][7:0]              cur_byte;

  // True when an address hits one of the six slot registers.
  function automatic logic slot_hit(input logic [7:0] a);
    return (a[7:4] == ATTP_OFF_SLOT_A[7:4] || a[7:4] == ATTP_OFF_SLOT_B[7:4])
           && a[3:2] < ATTP_REG_CNT;
  endfunction : slot_hit

  // Unit that owns a slot register address.
  function automatic logic slot_unit(input logic [7:0] a);
    return a[7:4] == ATTP_OFF_SLOT_B[7:4];
  endfunction : slot_unit

  // True when an address hits a stored conversion result.
  function automatic logic res_hit(input logic [7:0] a);
    return (a[7:6] == ATTP_OFF_RES_A[7:6] || a[7:6] == ATTP_OFF_RES_B[7:6])
           && a[5:2] < ATTP_IDX_END;
  endfunction : res_hit

  // Slot byte under each sequencer's index, zero once the index runs off the end.
  always_comb begin
    for (int u = 0; u < ATTP_UNITS; u++) begin
      cur_byte[u] = '0;
      // RL2 twelve slots
      if (q.unit[u].idx < ATTP_IDX_END) begin
        // RL10 slot packing
        cur_byte[u] = q.slots[u][q.unit[u].idx[3:2]][{q.unit[u].idx[1:0], 3'h0} +: 8];
      end
    end
  end

  // Next-state logic for sequencers, register file and bus slave.
  always_comb begin
    logic                  trig_rise;
    logic                  aw_fire;
    logic                  w_fire;
    logic                  ar_fire;
    logic [7:0]            wa;
    logic [31:0]           wd;
    logic [3:0]            ws;
    logic [ATTP_STS_W-1:0] clr;
    logic [ATTP_STS_W-1:0] evt;
    logic [7:0]            ra;
    trig_rise = timer5_match_event && !q.trig_prev;
    aw_fire   = awvalid && q.awready;
    w_fire    = wvalid && q.wready;
    ar_fire   = arvalid && q.arready;
    wa        = aw_fire ? awaddr : q.awaddr;
    wd        = w_fire ? wdata : q.wdata;
    ws        = w_fire ? wstrb : q.wstrb;
    clr       = '0;
    evt       = '0;
    ra        = q.araddr;
    d         = q;
    d.trig_prev = timer5_match_event;
    d.done      = '0;

    // RL8 per-unit sequencers
    for (int u = 0; u < ATTP_UNITS; u++) begin
      d.req[u].req = 1'b0;
      case (q.unit[u].state)
        ATTP_SEQ_IDLE: begin
          // RL1 timer trigger start
          if (trig_rise) begin
            d.unit[u].state = ATTP_SEQ_SCAN;
            d.unit[u].idx   = '0;
          end
        end
        ATTP_SEQ_SCAN: begin
          if (q.unit[u].idx == ATTP_IDX_END) begin
            // RL7 completion interrupt
            d.unit[u].state      = ATTP_SEQ_IDLE;
            d.done[u]            = 1'b1;
            evt[ATTP_STS_DONE+u] = 1'b1;
          end else if (!cur_byte[u][ATTP_EN_BIT]) begin
            // RL3 disabled slot skipped
            d.unit[u].idx = q.unit[u].idx + ATTP_IDX_STEP;
          end else if (cur_byte[u][ATTP_SEL_W-1:0] > ATTP_SEL_MAX[u]) begin
            // RL5 reserved code flagged
            evt[ATTP_STS_RSV+u] = 1'b1;
            d.unit[u].idx       = q.unit[u].idx + ATTP_IDX_STEP;
          end else begin
            // RL4 input select issued
            d.req[u].req    = 1'b1;
            d.req[u].sel    = cur_byte[u][ATTP_SEL_W-1:0];
            d.req[u].slot   = q.unit[u].idx;
            d.unit[u].state = ATTP_SEQ_CONV;
          end
        end
        ATTP_SEQ_CONV: begin
          // RL12 ascending, trigger ignored
          if (conv_rsp[u].done) begin
            d.unit[u].idx   = q.unit[u].idx + ATTP_IDX_STEP;
            d.unit[u].state = ATTP_SEQ_SCAN;
          end
        end
        default: begin
          d.unit[u].state = ATTP_SEQ_IDLE;
        end
      endcase
    end

    // Write channel capture; address and data may come in either order.
    if (aw_fire) begin
      d.awaddr = awaddr;
      d.aw_got = 1'b1;
    end
    if (w_fire) begin
      d.wdata = wdata;
      d.wstrb = wstrb;
      d.w_got = 1'b1;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held.
    if ((q.aw_got || aw_fire) && (q.w_got || w_fire)) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = ATTP_RESP_OKAY;
      if (slot_hit(wa)) begin
        for (int b = 0; b < 4; b++) begin
          if (ws[b]) begin
            // RL9 reserved bits kept zero
            d.slots[slot_unit(wa)][wa[3:2]][8*b +: 8] = wd[8*b +: 8] & ATTP_SLOT_WMASK[8*b +: 8];
          end
        end
      end else if (wa == ATTP_OFF_STATUS) begin
        clr = ws[0] ? wd[ATTP_STS_W-1:0] : '0;
      end else if (wa == ATTP_OFF_MASK) begin
        if (ws[0]) begin
          d.msk = wd[ATTP_STS_W-1:0];
        end
      end else if (!(wa == ATTP_OFF_BUSY || res_hit(wa))) begin
        d.bresp = ATTP_RESP_SLVERR;
      end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    d.sts     = (q.sts & ~clr) | evt;
    d.irq     = |(d.sts & d.msk);
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // Read channel: address taken, data one cycle later for the result store.
    if (ar_fire) begin
      d.araddr  = araddr;
      d.rd_wait = 1'b1;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (q.rd_wait) begin
      d.rd_wait = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = ATTP_RESP_OKAY;
      d.rdata   = '0;
      if (slot_hit(ra)) begin
        d.rdata = q.slots[slot_unit(ra)][ra[3:2]];
      end else if (ra == ATTP_OFF_STATUS) begin
        d.rdata[ATTP_STS_W-1:0] = q.sts;
      end else if (ra == ATTP_OFF_MASK) begin
        d.rdata[ATTP_STS_W-1:0] = q.msk;
      end else if (ra == ATTP_OFF_BUSY) begin
        for (int u = 0; u < ATTP_UNITS; u++) begin
          d.rdata[u] = q.unit[u].state != ATTP_SEQ_IDLE;
        end
      end else if (res_hit(ra)) begin
        d.rdata[ATTP_RES_W-1:0] = mem_rdata[ra[7:6] == ATTP_OFF_RES_B[7:6]];
      end else begin
        d.rresp = ATTP_RESP_SLVERR;
      end
    end
    d.arready = !d.rd_wait && !d.rvalid;
  end

  // RL11 cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // RL6 result written at slot index
  for (genvar g = 0; g < ATTP_UNITS; g++) begin : g_mem
    assign mem_we[g] = q.unit[g].state == ATTP_SEQ_CONV && conv_rsp[g].done;
    attp_result_mem u_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (mem_we[g]),
      .waddr   (q.unit[g].idx),
      .wdata   (conv_rsp[g].data),
      .raddr   (araddr[5:2]),
      .rdata   (mem_rdata[g])
    );
  end

  // Outputs straight from the state register.
  assign awready                 = q.awready;
  assign wready                  = q.wready;
  assign bresp                   = q.bresp;
  assign bvalid                  = q.bvalid;
  assign arready                 = q.arready;
  assign rdata                   = q.rdata;
  assign rresp                   = q.rresp;
  assign rvalid                  = q.rvalid;
  assign conv_req                = q.req;
  assign timer_sequence_done_irq = q.done;
  assign irq                     = q.irq;

  // Checks on the sequencers and the slot table.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_trig_idle;
    q.unit[0].state == ATTP_SEQ_IDLE && timer5_match_event && !q.trig_prev;
  endsequence

  sequence s_scan_live(int u);
    q.unit[u].state == ATTP_SEQ_SCAN && q.unit[u].idx < ATTP_IDX_END
      && cur_byte[u][ATTP_EN_BIT];
  endsequence

  property p_trig_start;
    s_trig_idle |=> q.unit[0].state == ATTP_SEQ_SCAN && q.unit[0].idx == '0;
  endproperty
  a_trig_start: assert property (p_trig_start) // RL1
    else $error("Timer event did not start a sequence.");
  property p_skip_off;
    q.unit[0].state == ATTP_SEQ_SCAN && q.unit[0].idx < ATTP_IDX_END
      && !cur_byte[0][ATTP_EN_BIT]
      |=> !conv_req[0].req && q.unit[0].idx == $past(q.unit[0].idx) + ATTP_IDX_STEP;
  endproperty
  a_skip_off: assert property (p_skip_off) // RL3
    else $error("Disabled slot was not skipped.");
  property p_req_sel;
    s_scan_live(0) ##0 cur_byte[0][ATTP_SEL_W-1:0] <= ATTP_SEL_MAX[0]
      |=> conv_req[0].req && conv_req[0].sel == $past(cur_byte[0][ATTP_SEL_W-1:0])
          && conv_req[0].slot == $past(q.unit[0].idx);
  endproperty
  a_req_sel: assert property (p_req_sel) // RL4
    else $error("Conversion request does not carry the slot select.");
  property p_unit_b_in12;
    s_scan_live(1) ##0 cur_byte[1][ATTP_SEL_W-1:0] == ATTP_SEL_MAX[1]
      |=> conv_req[1].req ##1 q.unit[1].state == ATTP_SEQ_CONV;
  endproperty
  a_unit_b_in12: assert property (p_unit_b_in12) // RL5
    else $error("Second unit refused input twelve.");
  property p_unit_a_in12;
    s_scan_live(0) ##0 cur_byte[0][ATTP_SEL_W-1:0] == ATTP_SEL_MAX[1]
      |=> !conv_req[0].req && q.sts[ATTP_STS_RSV];
  endproperty
  a_unit_a_in12: assert property (p_unit_a_in12) // RL5
    else $error("First unit converted a reserved code.");
  property p_result_slot;
    q.unit[0].state == ATTP_SEQ_CONV && conv_rsp[0].done
      |-> mem_we[0] && q.unit[0].idx == conv_req[0].slot;
  endproperty
  a_result_slot: assert property (p_result_slot) // RL6
    else $error("Result stored at the wrong index.");
  property p_seq_done;
    q.unit[0].state == ATTP_SEQ_SCAN && q.unit[0].idx == ATTP_IDX_END
      |=> timer_sequence_done_irq[0] && q.sts[ATTP_STS_DONE]
          && q.unit[0].state == ATTP_SEQ_IDLE ##1 !timer_sequence_done_irq[0];
  endproperty
  a_seq_done: assert property (p_seq_done) // RL7
    else $error("Sequence end did not pulse the done interrupt.");
  property p_rsv_zero;
    (q.slots & ~{(ATTP_UNITS*ATTP_SLOT_REGS){ATTP_SLOT_WMASK}}) == '0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // RL9
    else $error("Reserved slot bits are not zero.");
  property p_reset_clear;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> q.slots == '0 && q.unit[0].state == ATTP_SEQ_IDLE && !irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RL11
    else $error("Slots not cleared by reset.");

  property p_busy_hold;
    q.unit[0].state == ATTP_SEQ_CONV && !conv_rsp[0].done
      |=> q.unit[0].state == ATTP_SEQ_CONV && $stable(q.unit[0].idx);
  endproperty
  a_busy_hold: assert property (p_busy_hold) // RL12
    else $error("Sequence moved while a conversion was pending.");

endmodule : attp_top

/* File: pkg/attp_pkg.sv */
// Shared constants and types of the timer-trigger program block.
package attp_pkg;

  // Geometry of the slot table.
  localparam int ATTP_UNITS     = 2;
  localparam int ATTP_SLOT_REGS = 3;
  localparam int ATTP_RES_W     = 12;
  localparam int ATTP_STS_W     = 4;
  localparam int ATTP_EN_BIT    = 7;
  localparam int ATTP_SEL_W     = 5;
  localparam int ATTP_IDX_W     = 4;

  // Slot counting and the last legal input code of each unit.
  localparam logic [ATTP_IDX_W-1:0] ATTP_IDX_END  = 4'hC;
  localparam logic [ATTP_IDX_W-1:0] ATTP_IDX_STEP = 4'h1;
  localparam logic [1:0]            ATTP_REG_CNT  = 2'h3;
  localparam logic [ATTP_UNITS-1:0][ATTP_SEL_W-1:0] ATTP_SEL_MAX = {5'h0C, 5'h0B};

  // Register byte offsets.
  localparam logic [7:0] ATTP_OFF_SLOT_A = 8'h00;
  localparam logic [7:0] ATTP_OFF_SLOT_B = 8'h10;
  localparam logic [7:0] ATTP_OFF_STATUS = 8'h20;
  localparam logic [7:0] ATTP_OFF_MASK   = 8'h24;
  localparam logic [7:0] ATTP_OFF_BUSY   = 8'h28;
  localparam logic [7:0] ATTP_OFF_RES_A  = 8'h40;
  localparam logic [7:0] ATTP_OFF_RES_B  = 8'h80;

  // Writable bits of a slot register and its reset value.
  localparam logic [31:0] ATTP_SLOT_WMASK = 32'h9F9F_9F9F;
  localparam logic [31:0] ATTP_SLOT_RST   = 32'h0000_0000;

  // Status layout: done bits per unit, then reserved-code bits per unit.
  localparam int ATTP_STS_DONE = 0;
  localparam int ATTP_STS_RSV  = 2;

  // Bus responses.
  localparam logic [1:0] ATTP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ATTP_RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    ATTP_SEQ_IDLE,
    ATTP_SEQ_SCAN,
    ATTP_SEQ_CONV
  } attp_seq_t;

  // Per-unit sequencer state.
  typedef struct packed {
    attp_seq_t             state;
    logic [ATTP_IDX_W-1:0] idx;
  } attp_unit_t;

  // Request to a converter core.
  typedef struct packed {
    logic                  req;
    logic [ATTP_SEL_W-1:0] sel;
    logic [ATTP_IDX_W-1:0] slot;
  } attp_conv_req_t;

  // Answer from a converter core.
  typedef struct packed {
    logic                  done;
    logic [ATTP_RES_W-1:0] data;
  } attp_conv_rsp_t;

endpackage : attp_pkg

/* File: rtl/attp_result_mem.sv */
// Conversion result store of one converter unit, registered read port.
`timescale 1ns/100ps
module attp_result_mem (
  input  logic                            aclk,
  input  logic                            aresetn,
  input  logic                            we,
  input  logic [attp_pkg::ATTP_IDX_W-1:0] waddr,
  input  logic [attp_pkg::ATTP_RES_W-1:0] wdata,
  input  logic [attp_pkg::ATTP_IDX_W-1:0] raddr,
  output logic [attp_pkg::ATTP_RES_W-1:0] rdata
);
  import attp_pkg::*;

  localparam int ATTP_DEPTH = 12;

  typedef struct packed {
    logic [ATTP_DEPTH-1:0][ATTP_RES_W-1:0] words;
    logic [ATTP_RES_W-1:0]                 rdata;
  } attp_mem_state_t;

  attp_mem_state_t q;
  attp_mem_state_t d;

  // Writes land in the addressed word; reads past the end return zero.
  always_comb begin
    d = q;
    if (we && waddr < ATTP_IDX_END) begin
      d.words[waddr] = wdata;
    end
    d.rdata = (raddr < ATTP_IDX_END) ? q.words[raddr] : '0;
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;

endmodule : attp_result_mem

/* File: test/attp_conv_model.sv */
// Behavioural converter cores of both units, answering each request after a set delay.
`timescale 1ns/100ps
module attp_conv_model (
  input  logic                               aclk,
  input  logic                               aresetn,
  input  attp_pkg::attp_conv_req_t [1:0]     conv_req,
  input  logic [7:0]                         lat,
  output attp_pkg::attp_conv_rsp_t [1:0]     conv_rsp
);
  import attp_pkg::*;

  logic [1:0] pend_q;
  logic [7:0] cnt_q [2];
  logic [8:0] hold_q [2];

  // One conversion per unit; data toggles every cycle outside the done pulse.
  always_ff @(posedge aclk) begin
    for (int u = 0; u < 2; u++) begin
      if (!aresetn) begin
        pend_q[u]        <= 1'b0;
        conv_rsp[u].done <= 1'b0;
        conv_rsp[u].data <= 12'h5A5;
      end else if (conv_req[u].req) begin
        pend_q[u]        <= 1'b1;
        cnt_q[u]         <= lat;
        hold_q[u]        <= {conv_req[u].slot, conv_req[u].sel};
        conv_rsp[u].done <= 1'b0;
        conv_rsp[u].data <= ~conv_rsp[u].data;
      end else if (pend_q[u] && cnt_q[u] == 8'h00) begin
        pend_q[u]        <= 1'b0;
        conv_rsp[u].done <= 1'b1;
        conv_rsp[u].data <= {u[0], 2'b10, hold_q[u][4:0], hold_q[u][8:5]};
      end else begin
        if (pend_q[u]) begin
          cnt_q[u] <= cnt_q[u] - 8'h01;
        end
        conv_rsp[u].done <= 1'b0;
        conv_rsp[u].data <= ~conv_rsp[u].data;
      end
    end
  end
endmodule : attp_conv_model

/* File: test/adc_timer_trigger_program_tb.sv */
// Self-checking bench of the timer-trigger program block.
`timescale 1ns/100ps
module adc_timer_trigger_program_tb;
  import attp_pkg::*;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [7:0]            awaddr = '0, araddr = '0, lat = '0;
  logic                  awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tmr = 0;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = '0;
  logic                  awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]            bresp, rresp, done_irq;
  logic [31:0]           rdata;
  attp_conv_rsp_t [1:0]  conv_rsp;
  attp_conv_req_t [1:0]  conv_req;
  int                    errors = 0, cmp_count = 0;
  logic [31:0]           seed = 32'hce4b;
  logic [31:0]           slot_v [2][3];
  logic [8:0]            got_q [2][$];
  int                    dcnt [2];

  // Clock of 100 ns period.
  always #50 aclk = ~aclk;

  attp_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer5_match_event(tmr), .conv_rsp(conv_rsp), .conv_req(conv_req),
    .timer_sequence_done_irq(done_irq), .irq(irq));

  attp_conv_model i_core (.aclk(aclk), .aresetn(aresetn), .conv_req(conv_req), .lat(lat),
    .conv_rsp(conv_rsp));

  // Logs requests and completion pulses of each unit at the falling edge, where they are settled.
  always @(negedge aclk) begin
    for (int u = 0; u < 2; u++) begin
      if (conv_req[u].req === 1'b1) got_q[u].push_back({conv_req[u].slot, conv_req[u].sel});
      if (done_irq[u] === 1'b1) dcnt[u]++;
    end
  end

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  function automatic logic legal(input int u, input logic [4:0] c);
    return c <= ((u == 1) ? 5'd12 : 5'd11);
  endfunction : legal

  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic ta, tw, tb, sa, sw, sb;
    int   n;
    {ta, tw, tb, n, r} = '0;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
    while (!tb && n < 200) begin
      @(negedge aclk);
      {sa, sw, sb} = {awready, wready, bvalid};
      if (sb) r = bresp;
      @(posedge aclk);
      n++;
      if (sa && !ta) awvalid <= 1'b0;
      if (sw && !tw) wvalid <= 1'b0;
      {ta, tw, tb} = {ta | sa, tw | sw, sb};
    end
    bready <= 1'b0;
    if (!tb) errors++;
  endtask : axw

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tb, sa, sb;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    {ta, tb, n, d, r} = '0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    while (!tb && n < 200) begin
      @(negedge aclk);
      {sa, sb} = {arready, rvalid};
      if (sb) {d, r} = {rdata, rresp};
      @(posedge aclk);
      n++;
      if (sa && !ta) arvalid <= 1'b0;
      {ta, tb} = {ta | sa, sb};
    end
    rready <= 1'b0;
    if (!tb) errors++;
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rdc

  task automatic trig();
    @(posedge aclk);
    tmr <= 1'b1;
    @(posedge aclk);
    tmr <= 1'b0;
  endtask : trig

  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    logic [31:0] v;
    logic [7:0]  by;
    logic [1:0]  r;
    logic [3:0]  st, mk, cl;
    int          n, p;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int a = 0; a < 44; a += 4) if (a != 12 && a != 28) rdc(a[7:0], 0, ATTP_RESP_OKAY);
    rdc(8'h0C, 0, ATTP_RESP_SLVERR);
    axw(8'h3C, 32'hFFFF_FFFF, 4'hF, r);
    chk(32'(r), 32'(ATTP_RESP_SLVERR));
    axw(8'h04, 32'hFFFF_FFFF, 4'h2, r);
    rdc(8'h04, 32'h0000_9F00, ATTP_RESP_OKAY);
    for (int it = 0; it < 3; it++) begin
      v = nxt();
      lat <= (it == 0) ? 8'd30 : {5'd0, v[2:0]};
      // legal codes only, plus three reserved ones on purpose in the first pass: two on unit 0, one on unit 1
      for (int u = 0; u < 2; u++) begin
        for (int k = 0; k < 3; k++) begin
          v = nxt();
          for (int b = 0; b < 4; b++) if (v[8*b+7]) v[8*b+:5] = 5'(nxt() % (u ? 13 : 12));
          if (it == 0 && k == 0) v[7:0] = 8'h8A;
          if (it == 0 && k == 1) v[15:8] = 8'h8C;
          if (it == 0 && k == 2) v[31:16] = u ? {8'hAD, v[23:16]} : 16'h8B9F;
          slot_v[u][k] = v;
          axw(8'(16 * u + 4 * k), v, 4'hF, r);
          chk(32'(r), 32'(ATTP_RESP_OKAY));
          rdc(8'(16 * u + 4 * k), v & 32'h9F9F_9F9F, ATTP_RESP_OKAY);
        end
        got_q[u].delete();
        dcnt[u] = 0;
      end
      trig();
      if (it == 0) begin
        rdc(8'h28, 32'h3, ATTP_RESP_OKAY);
        trig();
      end
      n = 0;
      while ((dcnt[0] == 0 || dcnt[1] == 0) && n < 3000) begin
        @(posedge aclk);
        n++;
      end
      repeat (40) @(posedge aclk);
      st = 4'h3;
      for (int u = 0; u < 2; u++) begin
        p = 0;
        for (int m = 0; m < 12; m++) begin
          by = slot_v[u][m / 4][8 * (m % 4)+:8];
          if (by[7] && legal(u, by[4:0])) begin
            chk(32'(got_q[u][p]), {23'd0, m[3:0], by[4:0]});
            rdc(8'((u ? 128 : 64) + 4 * m), {20'd0, u[0], 2'b10, by[4:0], m[3:0]},
                ATTP_RESP_OKAY);
            p++;
          end else if (by[7]) begin
            st[2 + u] = 1'b1;
          end
        end
        chk(32'(got_q[u].size()), 32'(p));
        chk(32'(dcnt[u]), 32'd1);
      end
      rdc(8'h20, {28'd0, st}, ATTP_RESP_OKAY);
      v = nxt();
      {cl, mk} = v[7:0];
      axw(8'h24, {28'd0, mk}, 4'h1, r);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({31'd0, irq}, {31'd0, |(st & mk)});
      axw(8'h20, {28'd0, cl}, 4'h1, r);
      st = st & ~cl;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({31'd0, irq}, {31'd0, |(st & mk)});
      rdc(8'h20, {28'd0, st}, ATTP_RESP_OKAY);
      axw(8'h20, 32'h0000_000F, 4'h1, r);
    end
    conclude();
  end
endmodule : adc_timer_trigger_program_tb
